// file: core/ppcw_pkg.sv
// ppcw_pkg: constants, field positions, reset values and carrier types for
// the six-pin port with pull control, change detection and low-power wake.
// assumes an 8-bit register port with single-cycle strobes and one clock.
package ppcw_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_PIN_DATA  = 8'h05; // port_pin_data
    localparam logic [7:0] OFF_DIR       = 8'h85; // port_direction
    localparam logic [7:0] OFF_PULL_EN   = 8'h95; // pull_enable
    localparam logic [7:0] OFF_CHG_EN    = 8'h96; // change_irq_enable
    localparam logic [7:0] OFF_PULL_POL  = 8'h97; // pull_polarity_select
    localparam logic [7:0] OFF_CTRL      = 8'hA0; // block control bits
    localparam logic [7:0] OFF_STATUS    = 8'hA1; // change flag status

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int PIN_W           = 6;  // pins 5..0
    localparam int BIT_PIN_ZERO    = 0;  // port_pin_zero
    localparam int BIT_PIN_THREE   = 3;  // port_pin_three
    localparam int BIT_PIN_FOUR    = 4;
    localparam int BIT_PIN_FIVE    = 5;
    localparam int BIT_GLB_PULL    = 0;  // control: global_pull_control
    localparam int BIT_CHG_IE      = 1;  // control: change interrupt enable
    localparam int BIT_GLB_IE      = 2;  // control: global_irq_enable
    localparam int BIT_LPW_EN      = 5;  // control: low_power_wake_enable
    localparam int BIT_CHG_FLAG    = 0;  // status: port_change_flag
    localparam int BIT_MISMATCH    = 1;  // status: live mismatch

    // ------------------------------------------------------------------
    // reset values and read masks
    // ------------------------------------------------------------------
    localparam logic [5:0] RST_DIR       = 6'h3F; // all inputs
    localparam logic [5:0] RST_PULL_EN   = 6'h37; // bit 3 unimplemented
    localparam logic [5:0] RST_PULL_POL  = 6'h37; // pull-up selected
    localparam logic [5:0] RST_CHG_EN    = 6'h00; // detection off
    localparam logic [5:0] RST_OUT_LATCH = 6'h00;
    localparam logic [5:0] RST_CMP_LATCH = 6'h00;
    localparam logic [5:0] MASK_PULL     = 6'h37; // implemented pull bits
    localparam logic [7:0] RD_UNMAPPED   = 8'h00;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PPCW_OSC_INTERNAL,
        PPCW_OSC_EXT_CLOCK,
        PPCW_OSC_LOW_POWER_XTAL,
        PPCW_OSC_STANDARD_XTAL,
        PPCW_OSC_HIGH_SPEED_XTAL
    } ppcw_osc_mode_t;

    // device configuration seen by the port
    typedef struct packed {
        ppcw_osc_mode_t osc_mode;          // oscillator mode
        logic           timer1_osc_en;     // timer1_oscillator running
        logic           crystal_out_func;  // pin 4 is crystal_output_function
        logic           ext_reset_pin;     // pin 3 is external_reset_pin
        logic           prog_mode;         // programming mode active
        logic           wake_up_reset_en;  // wake_up_reset feature on
        logic           sleep;             // core is sleeping
    } ppcw_cfg_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ppcw_bus_t;

endpackage : ppcw_pkg

// file: core/ppcw_port.sv
// ppcw_port: six-pin bidirectional port with direction, read-back, weak
// pull control, change detection with sticky flag, wake and current sink.
// assumes pins and configuration are synchronous inputs, one clock domain,
// rst_n_i is power-on reset and warm_rst_i a synchronous pin/brown-out reset.
`timescale 1ns/10ps

module ppcw_port
    import ppcw_pkg::*;
#(
    parameter int SYNC_STAGES = 2  // depth of the pin synchroniser
) (
    input  wire logic             core_clk_i,     // system clock
    input  wire logic             rst_n_i,        // power-on reset
    input  wire logic             warm_rst_i,     // pin or brown-out reset
    input  wire ppcw_bus_t        bus_i,          // register request
    output logic [7:0]            rd_data_o,      // read data, next cycle
    input  wire ppcw_cfg_t        cfg_i,          // device configuration
    input  wire logic [PIN_W-1:0] analog_sel_i,   // pin is analog input
    input  wire logic [PIN_W-1:0] clock_func_i,   // pin is a clock function
    input  wire logic [PIN_W-1:0] pin_i,          // pin levels
    output logic [PIN_W-1:0]      pin_o,          // output drive level
    output logic [PIN_W-1:0]      pin_oe_o,       // output enable
    output logic [PIN_W-1:0]      pull_up_o,      // weak pull-up on
    output logic [PIN_W-1:0]      pull_down_o,    // weak pull-down on
    output logic                  sink_en_o,      // pin-0 current sink
    output logic                  change_flag_o,  // port_change_flag
    output logic                  wake_o,         // wake request
    output logic                  irq_o,          // interrupt recognised
    output logic                  wake_vector_o   // resume at vector
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] dir_q;        // port_direction storage
    logic [PIN_W-1:0] pull_en_q;    // pull_enable storage
    logic [PIN_W-1:0] pull_pol_q;   // pull_polarity_select storage
    logic [PIN_W-1:0] chg_en_q;     // change_irq_enable storage
    logic [PIN_W-1:0] out_latch_q;  // output latch
    logic [PIN_W-1:0] cmp_latch_q;  // comparison latch
    logic [7:0]       ctrl_q;       // control register
    logic             flag_q;       // port_change_flag

    // ------------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] sync_q [SYNC_STAGES];  // stage 0 read only by stage 1
    logic [PIN_W-1:0] pin_s;                 // synchronised pin levels

    // shift pins through the stages
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                sync_q[i] <= '0;
            end
        end else begin
            sync_q[0] <= pin_i;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                sync_q[i] <= sync_q[i-1];
            end
        end
    end

    assign pin_s = sync_q[SYNC_STAGES-1];

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire sel_data   = (bus_i.addr == OFF_PIN_DATA);
    wire sel_dir    = (bus_i.addr == OFF_DIR);
    wire sel_pull   = (bus_i.addr == OFF_PULL_EN);
    wire sel_chg    = (bus_i.addr == OFF_CHG_EN);
    wire sel_pol    = (bus_i.addr == OFF_PULL_POL);
    wire sel_ctrl   = (bus_i.addr == OFF_CTRL);
    wire sel_status = (bus_i.addr == OFF_STATUS);

    wire wr_data   = bus_i.wr & sel_data;
    wire wr_dir    = bus_i.wr & sel_dir;
    wire wr_pull   = bus_i.wr & sel_pull;
    wire wr_chg    = bus_i.wr & sel_chg;
    wire wr_pol    = bus_i.wr & sel_pol;
    wire wr_ctrl   = bus_i.wr & sel_ctrl;
    wire wr_status = bus_i.wr & sel_status;

    // any read or write of the data register reloads the comparison latch
    wire data_access = (bus_i.wr | bus_i.rd) & sel_data;

    // ------------------------------------------------------------------
    // configuration qualifiers
    // ------------------------------------------------------------------
    // any of the three crystal modes
    wire xtal_mode = (cfg_i.osc_mode == PPCW_OSC_LOW_POWER_XTAL) |
                     (cfg_i.osc_mode == PPCW_OSC_STANDARD_XTAL)  |
                     (cfg_i.osc_mode == PPCW_OSC_HIGH_SPEED_XTAL);

    // pin-5 pull bit writable only on internal oscillator, timer1 osc off
    wire pull5_open = (cfg_i.osc_mode == PPCW_OSC_INTERNAL) &
                      ~cfg_i.timer1_osc_en;
    // pin-4 pull bit writable only while pin 4 is not crystal output
    wire pull4_open = ~cfg_i.crystal_out_func;

    // bits software may change in the pull-enable register
    wire [PIN_W-1:0] pull_wmask = MASK_PULL &
                                  ~{~pull5_open, ~pull4_open, 4'h0};

    // ------------------------------------------------------------------
    // effective (read-back) views of the registers
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] pull_en_eff;  // locked bits read as one
    logic [PIN_W-1:0] dir_eff;      // forced input bits read as one
    logic [PIN_W-1:0] chg_en_eff;   // bits forced off in crystal modes
    logic [PIN_W-1:0] chg_en_act;   // enables actually used for compare

    always_comb begin
        pull_en_eff = pull_en_q & MASK_PULL;
        if (!pull5_open) begin
            pull_en_eff[BIT_PIN_FIVE] = 1'b1;
        end
        if (!pull4_open) begin
            pull_en_eff[BIT_PIN_FOUR] = 1'b1;
        end
    end
    always_comb begin
        dir_eff = dir_q;
        dir_eff[BIT_PIN_THREE] = 1'b1;
        if (xtal_mode) begin
            dir_eff[BIT_PIN_FIVE] = 1'b1;
            dir_eff[BIT_PIN_FOUR] = 1'b1;
        end
    end
    always_comb begin
        chg_en_eff = chg_en_q;
        if (xtal_mode) begin
            chg_en_eff[BIT_PIN_FIVE] = 1'b0;
            chg_en_eff[BIT_PIN_FOUR] = 1'b0;
        end
        chg_en_act = chg_en_eff;
        if (cfg_i.wake_up_reset_en && cfg_i.sleep) begin
            chg_en_act[BIT_PIN_THREE] = 1'b0;
        end
    end

    // digital pin levels: analog pins always read zero
    wire [PIN_W-1:0] pin_read = pin_s & ~analog_sel_i;

    // ------------------------------------------------------------------
    // change detection
    // ------------------------------------------------------------------
    // enabled pins that differ from the level latched at the last access
    wire [PIN_W-1:0] mismatch_vec = (pin_s ^ cmp_latch_q) & chg_en_act;
    wire             mismatch     = |mismatch_vec;

    // the latch reload in an access cycle does not hide a change in that same
    // cycle; mismatch still compares against the old latch and sets the flag
    wire [PIN_W-1:0] next_cmp_latch = data_access ? pin_s : cmp_latch_q;

    // software clear by writing one; a mismatch in the same cycle wins
    wire flag_clear = wr_status & bus_i.wdata[BIT_CHG_FLAG];
    wire next_flag  = mismatch | (flag_q & ~flag_clear);

    // ------------------------------------------------------------------
    // pull control
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] pull_on;  // pull device active per pin

    always_comb begin
        pull_on = {PIN_W{ctrl_q[BIT_GLB_PULL]}} & dir_eff & pull_en_eff &
                  ~analog_sel_i & ~clock_func_i;
        pull_on[BIT_PIN_THREE] = cfg_i.ext_reset_pin & ~cfg_i.prog_mode;
    end

    // pin 3 only ever has a pull-up
    wire [PIN_W-1:0] pol_eff = pull_pol_q | (6'h01 << BIT_PIN_THREE);
    wire [PIN_W-1:0] next_pull_up   = pull_on & pol_eff;
    wire [PIN_W-1:0] next_pull_down = pull_on & ~pol_eff;

    // ------------------------------------------------------------------
    // wake and interrupt
    // ------------------------------------------------------------------
    wire chg_ie    = ctrl_q[BIT_CHG_IE];
    wire glb_ie    = ctrl_q[BIT_GLB_IE];
    wire next_wake = next_flag & chg_ie;
    wire next_irq  = next_wake & glb_ie;
    wire next_vec  = next_wake & glb_ie & cfg_i.sleep;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [7:0] next_rd_data;

    always_comb begin
        next_rd_data = RD_UNMAPPED;
        if (bus_i.rd) begin
            if (sel_data) begin
                next_rd_data = {2'h0, pin_read};
            end else if (sel_dir) begin
                next_rd_data = {2'h0, dir_eff};
            end else if (sel_pull) begin
                next_rd_data = {2'h0, pull_en_eff};
            end else if (sel_chg) begin
                next_rd_data = {2'h0, chg_en_eff};
            end else if (sel_pol) begin
                next_rd_data = {2'h0, pull_pol_q & MASK_PULL};
            end else if (sel_ctrl) begin
                next_rd_data = ctrl_q;
            end else if (sel_status) begin
                next_rd_data = {6'h00, mismatch, flag_q};
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration registers: power-on and warm reset both restore
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_q      <= RST_DIR;
            pull_en_q  <= RST_PULL_EN;
            pull_pol_q <= RST_PULL_POL;
            chg_en_q   <= RST_CHG_EN;
            ctrl_q     <= 8'h00;
        end else if (warm_rst_i) begin
            dir_q      <= RST_DIR;
            pull_en_q  <= RST_PULL_EN;
            pull_pol_q <= RST_PULL_POL;
            chg_en_q   <= RST_CHG_EN;
            ctrl_q     <= 8'h00;
        end else begin
            if (wr_dir) begin
                dir_q <= bus_i.wdata[PIN_W-1:0];
            end
            if (wr_pull) begin
                pull_en_q <= (bus_i.wdata[PIN_W-1:0] & pull_wmask) |
                             (pull_en_q & ~pull_wmask);
            end
            if (wr_pol) begin
                pull_pol_q <= bus_i.wdata[PIN_W-1:0] & MASK_PULL;
            end
            if (wr_chg) begin
                chg_en_q <= bus_i.wdata[PIN_W-1:0];
            end
            if (wr_ctrl) begin
                ctrl_q <= bus_i.wdata & 8'h27;
            end
        end
    end

    // ------------------------------------------------------------------
    // output latch: a byte write carries the modified pin image
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_latch_q <= RST_OUT_LATCH;
        end else if (wr_data) begin
            out_latch_q <= bus_i.wdata[PIN_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // comparison latch: only power-on reset touches it
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_latch_q <= RST_CMP_LATCH;
        end else begin
            cmp_latch_q <= next_cmp_latch;
        end
    end

    // ------------------------------------------------------------------
    // change flag: warm reset clears, a live mismatch sets it again
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_q <= 1'b0;
        end else if (warm_rst_i) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= next_flag;
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o     <= 8'h00;
            pin_o         <= '0;
            pin_oe_o      <= '0;
            pull_up_o     <= '0;
            pull_down_o   <= '0;
            sink_en_o     <= 1'b0;
            wake_o        <= 1'b0;
            irq_o         <= 1'b0;
            wake_vector_o <= 1'b0;
        end else begin
            rd_data_o     <= next_rd_data;
            pin_o         <= out_latch_q;
            pin_oe_o      <= ~dir_eff;
            pull_up_o     <= next_pull_up;
            pull_down_o   <= next_pull_down;
            sink_en_o     <= ctrl_q[BIT_LPW_EN];
            wake_o        <= next_wake & ~warm_rst_i;
            irq_o         <= next_irq & ~warm_rst_i;
            wake_vector_o <= next_vec & ~warm_rst_i;
        end
    end

    assign change_flag_o = flag_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_pull_rsvd;
        bus_i.rd && sel_pull |=> rd_data_o[7:6] == 2'h0 && !rd_data_o[3];
    endproperty
    a_pull_rsvd: assert property (p_pull_rsvd) else $error("pull reserved bits");

    property p_pull5_lock;
        bus_i.rd && sel_pull && !pull5_open |=> rd_data_o[5];
    endproperty
    a_pull5_lock: assert property (p_pull5_lock) else $error("pin5 pull lock");

    property p_data_read;
        bus_i.rd && sel_data |=> rd_data_o == {2'h0, $past(pin_s & ~analog_sel_i)};
    endproperty
    a_data_read: assert property (p_data_read) else $error("data read wrong");

    property p_drive;
        !warm_rst_i ##1 1'b1 |-> pin_oe_o[2:0] == ~$past(dir_q[2:0]);
    endproperty
    a_drive: assert property (p_drive) else $error("output enable wrong");

    property p_dir3;
        bus_i.rd && sel_dir |=> rd_data_o[3];
    endproperty
    a_dir3: assert property (p_dir3) else $error("pin3 direction");

    property p_xtal_chg;
        bus_i.rd && sel_chg && xtal_mode |=> rd_data_o[5:4] == 2'h0;
    endproperty
    a_xtal_chg: assert property (p_xtal_chg) else $error("crystal change en");

    property p_set;
        mismatch && !warm_rst_i |=> flag_q;
    endproperty
    a_set: assert property (p_set) else $error("mismatch lost");

    property p_reload;
        data_access |=> cmp_latch_q == $past(pin_s);
    endproperty
    a_reload: assert property (p_reload) else $error("latch not reloaded");

    property p_wake;
        flag_q && chg_ie && mismatch && !warm_rst_i |=> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake missing");

    property p_irq_gie;
        irq_o |-> $past(glb_ie) && $past(chg_ie);
    endproperty
    a_irq_gie: assert property (p_irq_gie) else $error("irq without enable");

    property p_sink;
        ctrl_q[BIT_LPW_EN] |=> sink_en_o;
    endproperty
    a_sink: assert property (p_sink) else $error("sink off");
endmodule : ppcw_port

// file: bench/ppcw_pin_model.sv
// pin side of the port: external drivers plus an RC network.
// assumes the bench picks which pins it drives from outside.
`timescale 1ns/10ps
module ppcw_pin_model #(
    parameter int DISCH_CYC = 24  // one less than the sink cycles until the cap reads low
) (
    input  wire logic       clk_i,
    input  wire logic [5:0] out_i,
    input  wire logic [5:0] oe_i,
    input  wire logic       sink_i,
    input  wire logic [5:0] ext_i,
    input  wire logic [5:0] drv_i,
    output logic [5:0]      lvl_o
);
    logic cap = 1'b0;  // capacitor above the high threshold
    int   cnt = 0;     // discharge time so far
    // charges while pin 0 drives high, drains slowly under the sink
    always @(posedge clk_i) begin
        if (oe_i[0] && out_i[0]) begin
            cap <= 1'b1;
            cnt <= 0;
        end else if (sink_i && cap) begin
            cnt <= cnt + 1;
            if (cnt == DISCH_CYC) cap <= 1'b0;
        end
    end
    // port driver wins, then the outside source, then the capacitor
    always_comb begin
        for (int k = 0; k < 6; k++) lvl_o[k] = oe_i[k] ? out_i[k] : drv_i[k] ? ext_i[k] : cap;
    end
endmodule : ppcw_pin_model

// file: bench/ppcw_port_bench.sv
// self-checking bench for the six-pin port.
// assumes the pin model closes the loop from pin outputs to pin_i.
`timescale 1ns/10ps
module ppcw_port_bench;
    import ppcw_pkg::*;
    logic core_clk_i = 0, rst_n_i = 0, wrst = 0, sink, flag, wake, irq, vec;
    ppcw_bus_t bus = '0;
    ppcw_cfg_t cfg = '0;
    logic [5:0] ana = '0, clkf = '0, ext = 6'h15, drv = 6'h3F, lvl, po, oe, pu, pd, v;
    logic [7:0] rdat;
    integer n_fail = 0, cmp_count = 0, seed = 32'h89e5e240, i;
    always #4 core_clk_i = ~core_clk_i;
    ppcw_port uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .warm_rst_i(wrst),
        .bus_i(bus), .rd_data_o(rdat), .cfg_i(cfg), .analog_sel_i(ana),
        .clock_func_i(clkf), .pin_i(lvl), .pin_o(po), .pin_oe_o(oe), .pull_up_o(pu),
        .pull_down_o(pd), .sink_en_o(sink), .change_flag_o(flag), .wake_o(wake),
        .irq_o(irq), .wake_vector_o(vec));
    ppcw_pin_model pins (.clk_i(core_clk_i), .out_i(po), .oe_i(oe), .sink_i(sink),
        .ext_i(ext), .drv_i(drv), .lvl_o(lvl));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // one-cycle write strobe, then one idle edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk_i);
        bus <= '0;
        @(posedge core_clk_i);
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk_i);
        bus <= '0;
        #1 chk(rdat, e);
        @(posedge core_clk_i);
    endtask : rd
    task automatic wrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        wr(a, d);
        rd(a, e);
    endtask : wrd
    // bounded wait for the change flag
    task automatic wait_flag;
        for (i = 0; i < 80 && flag !== 1'b1; i++) @(posedge core_clk_i);
        chk({7'h0, flag}, 8'h01);
        if (flag !== 1'b1) give_verdict();
    endtask : wait_flag
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        rd(OFF_CHG_EN, 8'h00);
        rd(8'h10, RD_UNMAPPED);
        wrd(OFF_PULL_EN, 8'hFF, 8'h37);
        wrd(OFF_PULL_EN, 8'h00, 8'h00);
        cfg.timer1_osc_en <= 1'b1;
        cfg.crystal_out_func <= 1'b1;
        wrd(OFF_PULL_EN, 8'h37, 8'h37);
        cfg <= '0;
        rd(OFF_PULL_EN, 8'h07);
        for (int m = 2; m < 5; m++) begin
            cfg.osc_mode <= ppcw_osc_mode_t'(m);
            wrd(OFF_DIR, 8'h00, 8'h38);
            wrd(OFF_CHG_EN, 8'h3F, 8'h0F);
        end
        cfg <= '0;
        wrd(OFF_DIR, 8'h00, 8'h08);
        chk({2'b0, oe}, 8'h37);
        for (int n = 0; n < 20; n++) begin
            v = 6'($random(seed));
            ana <= 6'($random(seed));
            ext <= v;
            wr(OFF_PIN_DATA, {2'b11, v});
            repeat (4) @(posedge core_clk_i);
            rd(OFF_PIN_DATA, {2'b00, v & ~ana});
        end
        ana <= '0;
        ext <= 6'h15;
        wr(OFF_DIR, 8'h3F);
        wr(OFF_CTRL, 8'h06);
        repeat (4) @(posedge core_clk_i);
        rd(OFF_PIN_DATA, 8'h15);
        // flag left over from the random loop must be gone before the change
        wr(OFF_STATUS, 8'h01);
        chk({7'h0, flag}, 8'h00);
        chk({5'h0, wake, irq, vec}, 8'h00);
        ext <= 6'h11;
        wait_flag();
        chk({5'h0, wake, irq, vec}, 8'h06);
        wr(OFF_STATUS, 8'h01);
        chk({7'h0, flag}, 8'h01);
        rd(OFF_PIN_DATA, 8'h11);
        wr(OFF_STATUS, 8'h01);
        chk({7'h0, flag}, 8'h00);
        wrst <= 1'b1;
        @(posedge core_clk_i);
        wrst <= 1'b0;
        wr(OFF_CHG_EN, 8'h3F);
        wr(OFF_STATUS, 8'h01);
        chk({7'h0, flag}, 8'h00);
        drv <= 6'h3E;
        wr(OFF_PIN_DATA, 8'h01);
        wr(OFF_DIR, 8'h3E);
        wr(OFF_CHG_EN, 8'h01);
        wr(OFF_DIR, 8'h3F);
        rd(OFF_PIN_DATA, 8'h11);
        // charging glitches set the flag; clear it so the wake is real
        wr(OFF_STATUS, 8'h01);
        chk({7'h0, flag}, 8'h00);
        wr(OFF_CTRL, 8'h22);
        @(posedge core_clk_i);
        chk({7'h0, sink}, 8'h01);
        cfg.sleep <= 1'b1;
        wait_flag();
        chk({5'h0, wake, irq, vec}, 8'h04);
        // global enable on while asleep: resume at the vector
        wr(OFF_CTRL, 8'h26);
        @(posedge core_clk_i);
        chk({5'h0, wake, irq, vec}, 8'h07);
        cfg.sleep <= 1'b0;
        cfg.ext_reset_pin <= 1'b1;
        v = 6'($random(seed)) & 6'h37;
        clkf <= v;
        wr(OFF_CTRL, 8'h01);
        repeat (3) @(posedge core_clk_i);
        chk({2'b0, pu}, {2'b0, (6'h37 & ~v) | 6'h08});
        chk({2'b0, pd}, 8'h00);
        // pull-down selection, and pin 3 pull-up off in programming mode
        cfg.prog_mode <= 1'b1;
        wr(OFF_PULL_POL, 8'h00);
        repeat (2) @(posedge core_clk_i);
        chk({2'b0, pu}, 8'h00);
        chk({2'b0, pd}, {2'b0, 6'h37 & ~v});
        give_verdict();
    end
endmodule : ppcw_port_bench
